// *** dv/hsps_load_model.sv ***
// partner model: load that reaches full enhancement some time after switch-on
`timescale 1ns/100ps
module hsps_load_model #(
    parameter int unsigned ENH_CYC = 1100
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // switch and enhancement
    input  wire logic switch_on,
    output logic      fully_enhanced
);
    int unsigned cnt_q;
    // longer than the slowest ramp, so the setpoint has settled first; lost as soon as the switch opens
    always_ff @(posedge clk_sys) begin
        if (reset || !switch_on) begin
            cnt_q          <= 0;
            fully_enhanced <= 1'b0;
        end else begin
            if (cnt_q < ENH_CYC) cnt_q <= cnt_q + 1;
            fully_enhanced <= (cnt_q >= ENH_CYC);
        end
    end
endmodule // hsps_load_model

// *** dv/tb_hot_swap_power_good_sequencer.sv ***
// testbench: start-up, fault filters, disable and apb reads of the sequencer
`timescale 1ns/100ps
module tb_hot_swap_power_good_sequencer;
    logic        clk_sys, reset, psel, penable, pwrite, lockout, present, pready, pslverr;
    logic        sw_on, sel, pg, pg_n, enh;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0]  flt;
    logic [9:0]  cfg_ma, limit, exp_lim;
    logic [3:0]  cfg_rise;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int          bad_count, n_checks, n;

    hsps_top #(.DIS_FILT_CYC(20), .UVOV_FILT_CYC(20), .OC_FILT_CYC(30), .PG_DLY_CYC(40),
               .START_DLY_CYC(10), .CYC_PER_MS(100)) hsps_top_i (
        .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .undervoltage_lockout(lockout),
        .disable_above(flt[0]), .disable_below(flt[4]), .over_temp(flt[1]), .uv_ov_fault(flt[2]),
        .over_current(flt[3]), .fully_enhanced(enh), .charge_cfg_present(present), .charge_cfg_ma(cfg_ma),
        .charge_cfg_rise_ms(cfg_rise), .switch_on(sw_on), .overcurrent_limit_sel(sel),
        .charge_current_limit(limit), .power_ok_high(pg), .power_ok_low_n(pg_n));
    hsps_load_model #(.ENH_CYC(1100)) hsps_load_model_i (
        .clk_sys(clk_sys), .reset(reset), .switch_on(sw_on), .fully_enhanced(enh));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task chk(input logic c);
        n_checks++;
        if (c !== 1'b1) begin
            bad_count++;
            $display("ERROR %0t: output check failed", $time);
        end
    endtask
    task conclude;
        if (bad_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // d is write data, or for a read the expected {pslverr, prdata}
    task apb(input logic w, input logic [7:0] a, input logic [32:0] d);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d[31:0];
        if (!w) exp_q.push_back(d);
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            n_checks++;
            if ({pslverr, prdata} !== e) begin
                bad_count++;
                $display("ERROR %0t: read data mismatch", $time);
            end
        end
    end
    task hold(input logic [4:0] m, input int c);
        flt <= m;
        repeat (c) @(posedge clk_sys);
    endtask
    task wait_hi(input int k);
        n = 0;
        while ((k == 0 ? sw_on : k == 1 ? enh : pg) !== 1'b1 && n < 5000) begin
            @(posedge clk_sys);
            n++;
        end
        chk(n < 5000);
    endtask
    task bring_up;
        wait_hi(0);
        chk(limit < exp_lim);
        wait_hi(1);
        chk(limit === exp_lim && sel === 1'b0 && pg === 1'b0);
        wait_hi(2);
        chk(n >= 40 && n <= 44);
        chk(sel === 1'b1 && sw_on === 1'b1 && pg_n === 1'b0);
    endtask

    initial begin
        #400000;
        bad_count++;
        conclude;
    end
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata, lockout, present, flt} = {1'b1, 44'h0, 1'b1, 5'h00};
        {bad_count, n_checks} = 0;
        n        = $urandom(2586);
        cfg_ma   = 10'h032 + 10'($urandom % 451);
        cfg_rise = 4'h1 + 4'($urandom % 10);
        exp_lim  = cfg_ma;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk(sw_on === 1'b0 && pg === 1'b0 && pg_n === 1'b1);
        apb(1'b0, 8'h04, {1'b0, hsps_pkg::CHG_RESET});
        apb(1'b0, 8'h10, 33'h100000000);
        apb(1'b1, 8'h00, 33'h000000001);
        apb(1'b0, 8'h00, 33'h000000001);
        apb(1'b1, 8'h00, 33'h000000000);
        flt     <= 5'h01;
        lockout <= 1'b1;
        repeat (50) @(posedge clk_sys);
        chk(sw_on === 1'b0 && pg === 1'b0);
        apb(1'b0, 8'h04, {13'h0, cfg_rise, 6'h0, cfg_ma});
        flt <= 5'h00;
        bring_up;
        hold(5'h01, 5 + $urandom % 14);
        hold(5'h00, 3);
        chk(pg === 1'b1);
        for (int i = 0; i < 2; i++) begin
            hold(i ? 5'h10 : 5'h01, 25);
            chk(pg === 1'b0 && pg_n === 1'b1 && sw_on === 1'b0);
            flt <= 5'h00;
            bring_up;
        end
        hold(5'h04, 15);
        hold(5'h00, 2);
        hold(5'h04, 15);
        chk(pg === 1'b1);
        hold(5'h04, 10);
        chk(pg === 1'b0 && sw_on === 1'b0);
        flt <= 5'h00;
        bring_up;
        hold(5'h02, 1190);
        chk(pg === 1'b1);
        hold(5'h02, 20);
        chk(pg === 1'b0);
        flt <= 5'h00;
        bring_up;
        hold(5'h08, 28);
        chk(pg === 1'b1);
        hold(5'h08, 10);
        chk(pg === 1'b0 && sw_on === 1'b0);
        hold(5'h00, 1);
        apb(1'b0, 8'h0c, 33'h000000001);
        hold(5'h01, 25);
        apb(1'b0, 8'h0c, 33'h000000000);
        flt <= 5'h00;
        bring_up;
        apb(1'b0, 8'h0c, 33'h000000000);
        // supply loss, then a reset in mid-run: the detected config is gone, defaults apply
        lockout <= 1'b0;
        present <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(sw_on === 1'b0 && pg === 1'b0 && pg_n === 1'b1);
        reset  <= 1'b1;
        cfg_ma <= 10'h032 + 10'($urandom % 451);
        @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk(sw_on === 1'b0 && pg_n === 1'b1 && limit === 10'h000);
        lockout <= 1'b1;
        exp_lim = hsps_pkg::CHG_MA_DEF;
        apb(1'b0, 8'h04, {13'h0, hsps_pkg::RISE_MS_DEF, 6'h0, hsps_pkg::CHG_MA_DEF});
        bring_up;
        // software override with values beyond the span: the latched config is clamped
        lockout <= 1'b0;
        apb(1'b1, 8'h04, {13'h0, 4'hf, 6'h0, 10'h3ff});
        apb(1'b1, 8'h00, 33'h000000002);
        lockout <= 1'b1;
        exp_lim = hsps_pkg::CHG_MA_MAX;
        apb(1'b0, 8'h04, {13'h0, hsps_pkg::RISE_MS_MAX, 6'h0, hsps_pkg::CHG_MA_MAX});
        bring_up;
        conclude;
    end
endmodule // tb_hot_swap_power_good_sequencer

// *** rtl/hsps_filter.sv ***
// persistence filter: flags a condition that has held for more than a cycle count
`timescale 1ns/100ps
module hsps_filter #(
    parameter int unsigned LIMIT = 1
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // condition and result
    input  wire logic cond,
    output logic      hit
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (!cond) begin
            cnt_d = 32'h0;
        end else if (cnt_q < LIMIT) begin
            cnt_d = cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // hit once the condition is seen in the cycle after LIMIT held cycles
    assign hit = cond && (cnt_q >= LIMIT);

    property p_clear;
        @(posedge clk_sys) disable iff (reset) !cond |=> cnt_q == 32'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("filter count not cleared");
endmodule // hsps_filter

// *** rtl/hsps_pkg.sv ***
// package: constants, register map and types of the hot swap power good sequencer
package hsps_pkg;
    localparam int unsigned CLK_MHZ        = 100;
    // timing figures in their own units
    localparam int unsigned DIS_FILT_US    = 1000;
    localparam int unsigned OT_FILT_US     = 12;
    localparam int unsigned UVOV_FILT_US   = 1000;
    localparam int unsigned OC_FILT_US     = 3000;
    localparam int unsigned PG_DLY_MS      = 20;
    localparam int unsigned START_DLY_MS   = 200;
    localparam int unsigned MS_US          = 1000;
    // derived cycle counts
    localparam int unsigned CYC_PER_MS     = MS_US * CLK_MHZ;
    localparam int unsigned DIS_FILT_CYC   = DIS_FILT_US * CLK_MHZ;
    localparam int unsigned OT_FILT_CYC    = OT_FILT_US * CLK_MHZ;
    localparam int unsigned UVOV_FILT_CYC  = UVOV_FILT_US * CLK_MHZ;
    localparam int unsigned OC_FILT_CYC    = OC_FILT_US * CLK_MHZ;
    localparam int unsigned PG_DLY_CYC     = PG_DLY_MS * CYC_PER_MS;
    localparam int unsigned START_DLY_CYC  = START_DLY_MS * CYC_PER_MS;
    // charge limit configuration, mA and ms
    localparam logic [9:0]  CHG_MA_MIN     = 10'h032;
    localparam logic [9:0]  CHG_MA_MAX     = 10'h1f4;
    localparam logic [9:0]  CHG_MA_DEF     = 10'h064;
    localparam logic [3:0]  RISE_MS_MIN    = 4'h1;
    localparam logic [3:0]  RISE_MS_MAX    = 4'ha;
    localparam logic [3:0]  RISE_MS_DEF    = 4'h1;
    // register map, byte addresses
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_CHG        = 8'h04;
    localparam logic [7:0]  OFS_STATUS     = 8'h08;
    localparam logic [7:0]  OFS_RETRY      = 8'h0c;
    localparam int unsigned CTRL_SW_DIS    = 0;
    localparam int unsigned CTRL_OVERRIDE  = 1;
    localparam logic [1:0]  CTRL_RESET     = 2'h0;
    localparam int unsigned CHG_MA_LSB     = 0;
    localparam int unsigned CHG_RISE_LSB   = 16;
    localparam logic [31:0] CHG_RESET      = 32'h00010064;
    localparam int unsigned ST_PG          = 4;
    localparam int unsigned ST_SW          = 5;
    localparam int unsigned ST_OVERCURRENT_LIMIT        = 6;
    localparam int unsigned ST_DIS         = 7;
    localparam int unsigned ST_CFG_EXT     = 8;

    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_CHARGE, ST_PGDLY, ST_NORMAL
    } hsps_state_t;
endpackage

// *** rtl/hsps_ramp.sv ***
// charge limit ramp: setpoint climbs from zero to the target over the rise time
`timescale 1ns/100ps
module hsps_ramp (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // ramp control
    hsps_ramp_if.ramp rif
);
    logic [9:0]  sp_q;
    logic [9:0]  sp_d;
    logic [31:0] acc_q;
    logic [31:0] acc_d;

    // bresenham step: target never exceeds rise cycles, so at most one step a cycle
    always_comb begin
        sp_d  = sp_q;
        acc_d = acc_q;
        if (rif.start) begin
            sp_d  = 10'h000;
            acc_d = 32'h0;
        end else if (sp_q < rif.target_ma) begin
            acc_d = acc_q + {22'h0, rif.target_ma};
            if (acc_d >= rif.rise_cyc) begin
                acc_d = acc_d - rif.rise_cyc;
                sp_d  = sp_q + 10'h001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sp_q  <= 10'h000;
            acc_q <= 32'h0;
        end else begin
            sp_q  <= sp_d;
            acc_q <= acc_d;
        end
    end

    assign rif.setpoint_ma = sp_q;
    assign rif.done        = (sp_q >= rif.target_ma);

    property p_ramp_bound;
        @(posedge clk_sys) disable iff (reset) !rif.start |=> sp_q <= $past(sp_q) + 10'h001;
    endproperty
    a_ramp_bound: assert property (p_ramp_bound) else $error("ramp step too large");
endmodule // hsps_ramp

// *** rtl/hsps_ramp_if.sv ***
// interface: charge limit ramp request and setpoint
`timescale 1ns/100ps
interface hsps_ramp_if;
    logic        start;
    logic [9:0]  target_ma;
    logic [31:0] rise_cyc;
    logic [9:0]  setpoint_ma;
    logic        done;
    modport ctl  (output start, output target_ma, output rise_cyc, input setpoint_ma, input done);
    modport ramp (input start, input target_ma, input rise_cyc, output setpoint_ma, output done);
endinterface

// *** rtl/hsps_top.sv ***
// top: hot swap power good sequencer with apb registers
// What this block does
// - power ok only when enhanced and normal
// - high and low power ok outputs agree
// - power ok follows enhancement by 20 ms
// - disable held over 1 ms drops power ok
// - over-temperature over 12 us drops power ok
// - under/overvoltage over 1 ms drops power ok
// - overcurrent over 3 ms drops power ok
// - start-up waits while disable is active
// - accepted disable clears retries, switch, power ok
// - disable pulses under 1 ms are ignored
// - disable active beyond 1.8 V either polarity
// - use detected charge config, else defaults
// - setpoint ramps from zero over rise time
// - enhancement moves limit to overcurrent limit
// - power ok enters normal, clears retries
// - charge limit spans 50 to 500 mA
// - rise time spans 1 to 10 ms
// - under/overvoltage: switch off, restart start delay
// - persistent overcurrent: new start delay, retry
`timescale 1ns/100ps
module hsps_top #(
    parameter int unsigned DIS_FILT_CYC  = hsps_pkg::DIS_FILT_CYC,
    parameter int unsigned UVOV_FILT_CYC = hsps_pkg::UVOV_FILT_CYC,
    parameter int unsigned OC_FILT_CYC   = hsps_pkg::OC_FILT_CYC,
    parameter int unsigned PG_DLY_CYC    = hsps_pkg::PG_DLY_CYC,
    parameter int unsigned START_DLY_CYC = hsps_pkg::START_DLY_CYC,
    parameter int unsigned CYC_PER_MS    = hsps_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // monitored conditions, from comparators
    input  wire logic        undervoltage_lockout,
    input  wire logic        disable_above,
    input  wire logic        disable_below,
    input  wire logic        over_temp,
    input  wire logic        uv_ov_fault,
    input  wire logic        over_current,
    input  wire logic        fully_enhanced,
    // detected charge configuration
    input  wire logic        charge_cfg_present,
    input  wire logic [9:0]  charge_cfg_ma,
    input  wire logic [3:0]  charge_cfg_rise_ms,
    // switch control and power ok
    output logic             switch_on,
    output logic             overcurrent_limit_sel,
    output logic [9:0]       charge_current_limit,
    output logic             power_ok_high,
    output logic             power_ok_low_n
);
    ////////////////////////////////////////////////////////////////////////////
    hsps_pkg::hsps_state_t state_q, state_d;
    logic [31:0] tmr_q, tmr_d;
    logic [7:0]  retry_q, retry_d;
    logic [1:0]  ctrl_q, ctrl_d;
    logic [31:0] chg_q, chg_d;
    logic [9:0]  lim_q, lim_d;
    logic [3:0]  rise_q, rise_d;
    logic        cfg_ext_q, cfg_ext_d;
    logic        undervoltage_lockout_q;
    logic        pg_q;
    logic [31:0] rdata_q, rdata_d;
    logic        disable_raw, dis_hit, ot_hit, uvov_hit, oc_hit, fault;
    logic        wr_en, addr_ok;

    // comparator outputs already flag 1.8 V beyond the reference either way
    assign disable_raw = disable_above || disable_below || ctrl_q[hsps_pkg::CTRL_SW_DIS];

    ////////////////////////////////////////////////////////////////////////////
    // persistence filters, all on clk_sys
    hsps_filter #(.LIMIT(DIS_FILT_CYC)) u_dis_filt (
        .clk_sys (clk_sys), .reset (reset), .cond (disable_raw), .hit (dis_hit));
    hsps_filter #(.LIMIT(hsps_pkg::OT_FILT_CYC)) u_ot_filt (
        .clk_sys (clk_sys), .reset (reset), .cond (over_temp), .hit (ot_hit));
    hsps_filter #(.LIMIT(UVOV_FILT_CYC)) u_uvov_filt (
        .clk_sys (clk_sys), .reset (reset), .cond (uv_ov_fault), .hit (uvov_hit));
    hsps_filter #(.LIMIT(OC_FILT_CYC)) u_oc_filt (
        .clk_sys (clk_sys), .reset (reset), .cond (over_current && overcurrent_limit_sel), .hit (oc_hit));

    assign fault = ot_hit || uvov_hit || oc_hit;

    ////////////////////////////////////////////////////////////////////////////
    // charge configuration latched when lockout is passed
    hsps_ramp_if rif ();
    hsps_ramp u_ramp (.clk_sys (clk_sys), .reset (reset), .rif (rif));

    always_comb begin
        lim_d     = lim_q;
        rise_d    = rise_q;
        cfg_ext_d = cfg_ext_q;
        if (undervoltage_lockout && !undervoltage_lockout_q) begin
            cfg_ext_d = charge_cfg_present || ctrl_q[hsps_pkg::CTRL_OVERRIDE];
            if (ctrl_q[hsps_pkg::CTRL_OVERRIDE]) begin
                lim_d  = chg_q[hsps_pkg::CHG_MA_LSB +: 10];
                rise_d = chg_q[hsps_pkg::CHG_RISE_LSB +: 4];
            end else if (charge_cfg_present) begin
                lim_d  = charge_cfg_ma;
                rise_d = charge_cfg_rise_ms;
            end else begin
                lim_d  = hsps_pkg::CHG_MA_DEF;
                rise_d = hsps_pkg::RISE_MS_DEF;
            end
            // clamp to the supported span
            if (lim_d < hsps_pkg::CHG_MA_MIN) lim_d = hsps_pkg::CHG_MA_MIN;
            if (lim_d > hsps_pkg::CHG_MA_MAX) lim_d = hsps_pkg::CHG_MA_MAX;
            if (rise_d < hsps_pkg::RISE_MS_MIN) rise_d = hsps_pkg::RISE_MS_MIN;
            if (rise_d > hsps_pkg::RISE_MS_MAX) rise_d = hsps_pkg::RISE_MS_MAX;
        end
    end

    assign rif.start     = (state_q != hsps_pkg::ST_CHARGE);
    assign rif.target_ma = lim_q;
    assign rif.rise_cyc  = 32'(rise_q) * 32'(CYC_PER_MS);

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        state_d = state_q;
        tmr_d   = tmr_q + 32'h1;
        retry_d = retry_q;
        unique case (state_q)
            hsps_pkg::ST_IDLE: begin
                tmr_d = 32'h0;
                if (undervoltage_lockout && !disable_raw) begin
                    state_d = hsps_pkg::ST_START;
                end
            end
            hsps_pkg::ST_START: begin
                if (uv_ov_fault) begin
                    tmr_d = 32'h0;               // supply must stay in range for the whole delay
                end else if (tmr_q >= START_DLY_CYC - 1) begin
                    state_d = hsps_pkg::ST_CHARGE;
                    tmr_d   = 32'h0;
                end
            end
            hsps_pkg::ST_CHARGE: begin
                tmr_d = 32'h0;
                if (fully_enhanced) begin
                    state_d = hsps_pkg::ST_PGDLY;
                end
            end
            hsps_pkg::ST_PGDLY: begin
                if (!fully_enhanced) begin
                    state_d = hsps_pkg::ST_CHARGE;
                end else if (tmr_q >= PG_DLY_CYC - 1) begin
                    state_d = hsps_pkg::ST_NORMAL;
                    retry_d = 8'h00;
                end
            end
            hsps_pkg::ST_NORMAL: begin
                tmr_d = 32'h0;
            end
        endcase
        // a fault outranks progress; disable outranks a fault
        if (state_q != hsps_pkg::ST_IDLE && state_q != hsps_pkg::ST_START && fault) begin
            state_d = hsps_pkg::ST_START;
            tmr_d   = 32'h0;
            retry_d = retry_q + 8'h01;
        end
        if (state_q == hsps_pkg::ST_START && (ot_hit || uvov_hit)) begin
            tmr_d = 32'h0;
        end
        if (dis_hit) begin
            state_d = hsps_pkg::ST_IDLE;
            tmr_d   = 32'h0;
            retry_d = 8'h00;
        end
        if (!undervoltage_lockout) begin
            state_d = hsps_pkg::ST_IDLE;
            tmr_d   = 32'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q   <= hsps_pkg::ST_IDLE;
            tmr_q     <= 32'h0;
            retry_q   <= 8'h00;
            lim_q     <= hsps_pkg::CHG_MA_DEF;
            rise_q    <= hsps_pkg::RISE_MS_DEF;
            cfg_ext_q <= 1'b0;
            undervoltage_lockout_q    <= 1'b0;
            pg_q      <= 1'b0;
        end else begin
            state_q   <= state_d;
            tmr_q     <= tmr_d;
            retry_q   <= retry_d;
            lim_q     <= lim_d;
            rise_q    <= rise_d;
            cfg_ext_q <= cfg_ext_d;
            undervoltage_lockout_q    <= undervoltage_lockout;
            pg_q      <= (state_d == hsps_pkg::ST_NORMAL) && fully_enhanced;
        end
    end

    assign switch_on             = (state_q == hsps_pkg::ST_CHARGE) || (state_q == hsps_pkg::ST_PGDLY)
                                   || (state_q == hsps_pkg::ST_NORMAL);
    assign overcurrent_limit_sel = (state_q == hsps_pkg::ST_PGDLY) || (state_q == hsps_pkg::ST_NORMAL);
    assign charge_current_limit  = rif.setpoint_ma;
    assign power_ok_high         = pg_q;
    assign power_ok_low_n        = !pg_q;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, read data captured in the setup cycle
    assign addr_ok = (paddr == hsps_pkg::OFS_CTRL) || (paddr == hsps_pkg::OFS_CHG)
                     || (paddr == hsps_pkg::OFS_STATUS) || (paddr == hsps_pkg::OFS_RETRY);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always_comb begin
        ctrl_d  = ctrl_q;
        chg_d   = chg_q;
        rdata_d = rdata_q;
        if (wr_en && paddr == hsps_pkg::OFS_CTRL) ctrl_d = pwdata[1:0];
        if (wr_en && paddr == hsps_pkg::OFS_CHG) begin
            chg_d = {12'h000, pwdata[hsps_pkg::CHG_RISE_LSB +: 4], 6'h00, pwdata[hsps_pkg::CHG_MA_LSB +: 10]};
        end
        if (psel && !penable) begin
            rdata_d = 32'h0;
            unique case (paddr)
                hsps_pkg::OFS_CTRL:   rdata_d = {30'h0, ctrl_q};
                hsps_pkg::OFS_CHG:    rdata_d = {12'h000, rise_q, 6'h00, lim_q};
                hsps_pkg::OFS_STATUS: rdata_d = {23'h0, cfg_ext_q, dis_hit, overcurrent_limit_sel,
                                                 switch_on, pg_q, 1'b0, state_q};
                hsps_pkg::OFS_RETRY:  rdata_d = {24'h0, retry_q};
                default:              rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_q  <= hsps_pkg::CTRL_RESET;
            chg_q   <= hsps_pkg::CHG_RESET;
            rdata_q <= 32'h0;
        end else begin
            ctrl_q  <= ctrl_d;
            chg_q   <= chg_d;
            rdata_q <= rdata_d;
        end
    end

    assign prdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_pg_cond;
        @(posedge clk_sys) disable iff (reset)
        power_ok_high |-> $past(fully_enhanced) && state_q == hsps_pkg::ST_NORMAL;
    endproperty
    a_pg_cond: assert property (p_pg_cond) else $error("power ok without enhancement");

    property p_pg_pair;
        @(posedge clk_sys) disable iff (reset) power_ok_high != power_ok_low_n;
    endproperty
    a_pg_pair: assert property (p_pg_pair) else $error("power ok pins disagree");

    property p_pg_delay;
        @(posedge clk_sys) disable iff (reset)
        $rose(power_ok_high) |-> $past(state_q) == hsps_pkg::ST_PGDLY && $past(tmr_q) == PG_DLY_CYC - 1;
    endproperty
    a_pg_delay: assert property (p_pg_delay) else $error("power ok early");

    property p_dis_drop;
        @(posedge clk_sys) disable iff (reset)
        dis_hit |=> !power_ok_high && !switch_on && retry_q == 8'h00;
    endproperty
    a_dis_drop: assert property (p_dis_drop) else $error("disable not honoured");

    property p_ot_drop;
        @(posedge clk_sys) disable iff (reset) ot_hit |=> !power_ok_high && !switch_on;
    endproperty
    a_ot_drop: assert property (p_ot_drop) else $error("over-temperature ignored");

    property p_uvov_drop;
        @(posedge clk_sys) disable iff (reset)
        uvov_hit && undervoltage_lockout && !dis_hit && (state_q != hsps_pkg::ST_IDLE || !disable_raw)
        |=> state_q == hsps_pkg::ST_START && !power_ok_high;
    endproperty
    a_uvov_drop: assert property (p_uvov_drop) else $error("supply fault ignored");

    property p_oc_retry;
        @(posedge clk_sys) disable iff (reset)
        oc_hit && undervoltage_lockout && !dis_hit |=> state_q == hsps_pkg::ST_START && tmr_q == 32'h0;
    endproperty
    a_oc_retry: assert property (p_oc_retry) else $error("overcurrent retry missing");

    property p_idle_hold;
        @(posedge clk_sys) disable iff (reset)
        state_q == hsps_pkg::ST_IDLE && disable_raw |=> state_q == hsps_pkg::ST_IDLE;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("left idle while disabled");

    property p_short_dis;
        @(posedge clk_sys) disable iff (reset)
        $rose(disable_raw) |-> (!dis_hit) [*8];
    endproperty
    a_short_dis: assert property (p_short_dis) else $error("short disable acted on");

    property p_limit_sel;
        @(posedge clk_sys) disable iff (reset)
        state_q == hsps_pkg::ST_CHARGE && fully_enhanced && !fault && !dis_hit && undervoltage_lockout
        |=> overcurrent_limit_sel;
    endproperty
    a_limit_sel: assert property (p_limit_sel) else $error("limit not switched");

    property p_span;
        @(posedge clk_sys) disable iff (reset)
        lim_q >= hsps_pkg::CHG_MA_MIN && lim_q <= hsps_pkg::CHG_MA_MAX && rise_q <= hsps_pkg::RISE_MS_MAX;
    endproperty
    a_span: assert property (p_span) else $error("charge config out of span");

    c_normal:  cover property (@(posedge clk_sys) disable iff (reset) $rose(power_ok_high));
    c_oc:      cover property (@(posedge clk_sys) disable iff (reset) oc_hit && state_q == hsps_pkg::ST_NORMAL);
    c_disable: cover property (@(posedge clk_sys) disable iff (reset) dis_hit && switch_on);
endmodule // hsps_top
